// *** verilog/rdc_pkg.sv ***
// Package of constants for the radio diagnostic and control register bank.
//
// Function
// - Control bits 14:9 hold the master clock frequency in whole MHz.
// - Deep-sleep request starts a slow-clock sequence that ends setting permit bit 8.
// - Permit bit clears when the core leaves sleep, with the sleep-exit interrupt.
// - Software may write only zero to slow-clock monitor bit 7.
// - Monitor bit sets on every rising edge of the slow clock while the slow timer is out of reset.
// - Monitor bit never sets while the slow timer is held in reset.
// - Read-only bit 6 shows the core clock: 0 slow, 1 master.
// - Bit 5 reverses the bit order of the probe bus toward the pins.
// - Unreversed: bus bit n drives port-0 pin n; bits 3:0 copy to port-1.
// - Reversed: bus bit n drives port-0 pin 7-n; port-1 copies port-0 3:0.
// - Select bits 4:3 build the probe bus from core or radio probe words; select 1 puts wake event and sleep state on bits 1:0.
// - Error mask bit 2 resets to 1; mask and flag together hold error interrupt.
// - Writing 1 to acknowledge bit 1 clears error flag; reads return 0.
// - Error flag bit 0 sets on access to an unmapped exchange-memory page.
// - Error flag ignores direct writes; only the acknowledge clears it.
// - Diagnostic register holds channels at 31:24, 23:16, 15:8, 7:0, fields reset 0.
// - Channel flag sets on chosen edge of chosen bit, clears on register read.
// - Channel edge bit: 0 selects rising, 1 selects falling edge.
// - Word select picks core words 0,1 or radio words 0,1; bit select picks bit.
// - Enabled channel raises the probe interrupt on each rise of its flag.

`default_nettype none

package rdc_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] RDC_CTL_ADDR  = 32'h4000_0200;
  localparam logic [31:0] RDC_DIAG_ADDR = 32'h4000_0204;

  // ==========================================================================
  // Control register field positions
  localparam int RDC_MHZ_LSB    = 9;
  localparam int RDC_MHZ_W      = 6;
  localparam int RDC_PERMIT_BIT = 8;
  localparam int RDC_MON_BIT    = 7;
  localparam int RDC_SRC_BIT    = 6;
  localparam int RDC_REV_BIT    = 5;
  localparam int RDC_SEL_LSB    = 3;
  localparam int RDC_MASK_BIT   = 2;
  localparam int RDC_ACK_BIT    = 1;
  localparam int RDC_FLAG_BIT   = 0;

  // ==========================================================================
  // Diagnostic channel field positions within one byte
  localparam int RDC_CH_W        = 8;
  localparam int RDC_CH_STAT_BIT = 7;
  localparam int RDC_CH_EDGE_BIT = 6;
  localparam int RDC_CH_BSEL_LSB = 3;
  localparam int RDC_CH_WSEL_LSB = 1;
  localparam int RDC_CH_EN_BIT   = 0;

  // ==========================================================================
  // Reset values and counts
  localparam logic [5:0] RDC_MHZ_RST    = 6'h00;
  localparam logic       RDC_MASK_RST   = 1'b1;
  localparam logic [7:0] RDC_CH_RST     = 8'h00;
  localparam logic [3:0] RDC_PERMIT_EDGES = 4'h2;

  // Power-down permission sequence states.
  typedef enum logic [1:0] {
    RDC_PD_IDLE   = 2'b00,
    RDC_PD_COUNT  = 2'b01,
    RDC_PD_PERMIT = 2'b10
  } rdc_pd_type;

endpackage : rdc_pkg

`default_nettype wire

// *** verilog/rdc_regs.sv ***
// Control, status and diagnostic register bank of the radio link-layer core.
`timescale 1ns/10ps
`default_nettype none

module rdc_regs
  import rdc_pkg::*;
#(
  parameter int         NUM_CHAN     = 4,
  parameter logic [3:0] PERMIT_EDGES = RDC_PERMIT_EDGES
)
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic        slow_clock_pin,
  input  wire logic        slow_timer_reset,
  input  wire logic        core_clock_source,
  input  wire logic        deep_sleep_request,
  input  wire logic        sleep_exit_interrupt,
  input  wire logic        xmem_access_fault,
  input  wire logic        slow_wake_event,
  input  wire logic        sleep_state_flag,
  input  wire logic [7:0]  core_probe_word0,
  input  wire logic [7:0]  core_probe_word1,
  input  wire logic [7:0]  core_probe_word2,
  input  wire logic [7:0]  rf_probe_word0,
  input  wire logic [7:0]  rf_probe_word1,
  output var  logic [5:0]  master_clock_mhz,
  output var  logic        power_down_permit,
  output var  logic [7:0]  port0_pins,
  output var  logic [3:0]  port1_pins,
  output var  logic        core_error_interrupt,
  output var  logic        probe_interrupt
);

  // ==========================================================================
  // Helper functions

  // Picks one of the four probe words for a diagnostic channel.
  function automatic logic [7:0] pick_word(input logic [1:0] wsel,
                                           input logic [7:0] w0,
                                           input logic [7:0] w1,
                                           input logic [7:0] w2,
                                           input logic [7:0] w3);
    logic [7:0] r;
    case (wsel)
      2'b00:   r = w0;
      2'b01:   r = w1;
      2'b10:   r = w2;
      default: r = w3;
    endcase
    return r;
  endfunction

  // Mirrors the bit order of a byte.
  function automatic logic [7:0] mirror(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = v[7-i];
    end
    return r;
  endfunction

  // ==========================================================================
  // Synchronisers for inputs from the slow domain

  // Bit 2 slow clock, bit 1 wake event, bit 0 sleep state.
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       slow_prev_q;
  logic       slow_rise;

  // The first stage feeds only the second; edges are taken after the second.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      meta_q      <= 3'h0;
      sync_q      <= 3'h0;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      meta_q      <= {slow_clock_pin, slow_wake_event, sleep_state_flag};
      sync_q      <= meta_q;
      slow_prev_q <= sync_q[2];
    end
  end

  assign slow_rise = sync_q[2] & ~slow_prev_q;

  // ==========================================================================
  // Bus decode

  logic ctl_wr;
  logic diag_wr;
  logic diag_rd;

  // Writes and reads act only on an exact word address.
  always_comb
  begin
    ctl_wr  = 1'b0;
    diag_wr = 1'b0;
    diag_rd = 1'b0;
    if (reg_addr == RDC_CTL_ADDR)
    begin
      ctl_wr = reg_wr;
    end
    else if (reg_addr == RDC_DIAG_ADDR)
    begin
      diag_wr = reg_wr;
      diag_rd = reg_rd;
    end
  end

  // ==========================================================================
  // Control register

  logic [5:0] mhz_q,  mhz_d;
  logic       mon_q,  mon_d;
  logic       src_q,  src_d;
  logic       rev_q,  rev_d;
  logic [1:0] sel_q,  sel_d;
  logic       mask_q, mask_d;
  logic       flag_q, flag_d;

  // Hardware sets win over software clears so no event is lost.
  always_comb
  begin
    mhz_d  = mhz_q;
    mon_d  = mon_q;
    rev_d  = rev_q;
    sel_d  = sel_q;
    mask_d = mask_q;
    flag_d = flag_q;
    src_d  = core_clock_source;
    if (ctl_wr)
    begin
      // Held stable by software while the core runs.
      mhz_d  = reg_wdata[RDC_MHZ_LSB +: RDC_MHZ_W];
      rev_d  = reg_wdata[RDC_REV_BIT];
      sel_d  = reg_wdata[RDC_SEL_LSB +: 2];
      mask_d = reg_wdata[RDC_MASK_BIT];
      if (!reg_wdata[RDC_MON_BIT])
        mon_d = 1'b0;
      if (reg_wdata[RDC_ACK_BIT])
        flag_d = 1'b0;
    end
    if (slow_rise && !slow_timer_reset)
      mon_d = 1'b1;
    if (xmem_access_fault)
      flag_d = 1'b1;
  end

  // Control register storage.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      mhz_q  <= RDC_MHZ_RST;
      mon_q  <= 1'b0;
      src_q  <= 1'b0;
      rev_q  <= 1'b0;
      sel_q  <= 2'b00;
      mask_q <= RDC_MASK_RST;
      flag_q <= 1'b0;
    end
    else
    begin
      mhz_q  <= mhz_d;
      mon_q  <= mon_d;
      src_q  <= src_d;
      rev_q  <= rev_d;
      sel_q  <= sel_d;
      mask_q <= mask_d;
      flag_q <= flag_d;
    end
  end

  // ==========================================================================
  // Power-down permission sequence

  rdc_pd_type pd_q, pd_d;
  logic [3:0] edge_cnt_q, edge_cnt_d;

  // Counting slow-clock edges keeps the permit aligned to the slow domain.
  always_comb
  begin
    pd_d       = pd_q;
    edge_cnt_d = edge_cnt_q;
    case (pd_q)
      RDC_PD_IDLE:
      begin
        edge_cnt_d = 4'h0;
        if (deep_sleep_request)
        begin
          pd_d = RDC_PD_COUNT;
        end
      end
      RDC_PD_COUNT:
      begin
        if (!deep_sleep_request)
        begin
          pd_d = RDC_PD_IDLE;
        end
        else if (slow_rise)
        begin
          edge_cnt_d = edge_cnt_q + 4'h1;
          if (edge_cnt_q + 4'h1 >= PERMIT_EDGES)
          begin
            pd_d = RDC_PD_PERMIT;
          end
        end
      end
      RDC_PD_PERMIT: pd_d = RDC_PD_PERMIT;
      default:       pd_d = RDC_PD_IDLE;
    endcase
    if (sleep_exit_interrupt)
      pd_d = RDC_PD_IDLE;
  end

  // Sequence state storage.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      pd_q       <= RDC_PD_IDLE;
      edge_cnt_q <= 4'h0;
    end
    else
    begin
      pd_q       <= pd_d;
      edge_cnt_q <= edge_cnt_d;
    end
  end

  // ==========================================================================
  // Diagnostic event channels

  logic [NUM_CHAN-1:0][7:0] ch_q, ch_d;
  logic [NUM_CHAN-1:0]      pick_prev_q, pick_prev_d;
  logic [NUM_CHAN-1:0]      ch_req;

  // A read clears every flag, but an edge in the same cycle still sets it.
  always_comb
  begin
    logic [7:0] word;
    logic       bit_now;
    logic       hit;
    word = 8'h00;
    bit_now = 1'b0;
    hit = 1'b0;
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      ch_d[c] = ch_q[c];
      word = pick_word(ch_q[c][RDC_CH_WSEL_LSB +: 2], core_probe_word0,
                       core_probe_word1, rf_probe_word0, rf_probe_word1);
      bit_now = word[ch_q[c][RDC_CH_BSEL_LSB +: 3]];
      pick_prev_d[c] = bit_now;
      if (ch_q[c][RDC_CH_EDGE_BIT])
        hit = pick_prev_q[c] & ~bit_now;
      else
        hit = ~pick_prev_q[c] & bit_now;
      if (diag_wr)
        ch_d[c][6:0] = reg_wdata[c*RDC_CH_W +: 7];
      if (diag_rd)
        ch_d[c][RDC_CH_STAT_BIT] = 1'b0;
      if (hit)
        ch_d[c][RDC_CH_STAT_BIT] = 1'b1;
      ch_req[c] = ch_q[c][RDC_CH_EN_BIT] & ch_d[c][RDC_CH_STAT_BIT]
                  & ~ch_q[c][RDC_CH_STAT_BIT];
    end
  end

  // Channel storage; the picked bit is tracked through reset so no false edge follows it.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        ch_q[c] <= RDC_CH_RST;
      end
      pick_prev_q <= pick_prev_d;
    end
    else
    begin
      ch_q        <= ch_d;
      pick_prev_q <= pick_prev_d;
    end
  end

  // ==========================================================================
  // Probe bus, read data and registered outputs

  logic [7:0]  probe_bus;
  logic [7:0]  pins_d;
  logic [31:0] rdata_d;

  // Probe bus mux, reverse stage and read-back assembly.
  always_comb
  begin
    case (sel_q)
      2'b00:   probe_bus = {core_probe_word2[7:5], core_probe_word1[4:3],
                            core_probe_word0[2:0]};
      2'b01:   probe_bus = {core_probe_word2[7:5], core_probe_word1[4:3],
                            core_probe_word0[2], sync_q[1], sync_q[0]};
      2'b10:   probe_bus = rf_probe_word0;
      default: probe_bus = rf_probe_word1;
    endcase
    pins_d = rev_q ? mirror(probe_bus) : probe_bus;
    rdata_d = 32'h0000_0000;
    if (reg_rd && reg_addr == RDC_CTL_ADDR)
    begin
      rdata_d[RDC_MHZ_LSB +: RDC_MHZ_W] = mhz_q;
      rdata_d[RDC_PERMIT_BIT]          = power_down_permit;
      rdata_d[RDC_MON_BIT]             = mon_q;
      rdata_d[RDC_SRC_BIT]             = src_q;
      rdata_d[RDC_REV_BIT]             = rev_q;
      rdata_d[RDC_SEL_LSB +: 2]        = sel_q;
      rdata_d[RDC_MASK_BIT]            = mask_q;
      rdata_d[RDC_FLAG_BIT]            = flag_q;
    end
    else if (diag_rd)
    begin
      for (int c = 0; c < NUM_CHAN; c++)
      begin
        rdata_d[c*RDC_CH_W +: RDC_CH_W] = ch_q[c];
      end
    end
  end

  // Every output leaves from a flop; pins lag the control bits by one cycle, interrupts and permit come from next-state values.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata            <= 32'h0000_0000;
      master_clock_mhz     <= RDC_MHZ_RST;
      power_down_permit    <= 1'b0;
      port0_pins           <= 8'h00;
      port1_pins           <= 4'h0;
      core_error_interrupt <= 1'b0;
      probe_interrupt      <= 1'b0;
    end
    else
    begin
      reg_rdata            <= rdata_d;
      master_clock_mhz     <= mhz_d;
      power_down_permit    <= (pd_d == RDC_PD_PERMIT);
      port0_pins           <= pins_d;
      port1_pins           <= pins_d[3:0];
      core_error_interrupt <= mask_d & flag_d;
      probe_interrupt      <= |ch_req;
    end
  end

endmodule // rdc_regs

`default_nettype wire

// *** tb/rdc_regs_sva.sv ***
// Concurrent checks on the ports of the radio diagnostic and control register bank.
`timescale 1ns/10ps
`default_nettype none

module rdc_sva
  import rdc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        sleep_exit_interrupt,
  input wire logic        xmem_access_fault,
  input wire logic [5:0]  master_clock_mhz,
  input wire logic        power_down_permit,
  input wire logic [7:0]  port0_pins,
  input wire logic [3:0]  port1_pins,
  input wire logic        core_error_interrupt
);
  // ==========================================================================
  // Decoded accesses; anything outside the two offsets must be ignored.
  wire logic ctl_wr = reg_wr && (reg_addr == RDC_CTL_ADDR);
  wire logic ctl_rd = reg_rd && (reg_addr == RDC_CTL_ADDR);
  wire logic unmap  = reg_rd && (reg_addr != RDC_CTL_ADDR) && (reg_addr != RDC_DIAG_ADDR);

  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // Acknowledge write with no fault in the same cycle, which would win.
  sequence s_ack;
    ctl_wr && reg_wdata[RDC_ACK_BIT] && !xmem_access_fault;
  endsequence

  property p_mirror; port1_pins == port0_pins[3:0]; endproperty
  a_mirror: assert property (p_mirror) else $error("port1 pins differ");
  property p_mhz; ctl_wr |=> master_clock_mhz == $past(reg_wdata[14:9]); endproperty
  a_mhz: assert property (p_mhz) else $error("clock field not taken");
  property p_rdmhz; ctl_rd |=> reg_rdata[14:9] == master_clock_mhz && !reg_rdata[1]; endproperty
  a_rdmhz: assert property (p_rdmhz) else $error("control read wrong");
  property p_idle; !reg_rd |=> reg_rdata == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside slot");
  property p_unmap; unmap |=> reg_rdata == 32'h0000_0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_erise; $rose(core_error_interrupt) |-> $past(xmem_access_fault || ctl_wr); endproperty
  a_erise: assert property (p_erise) else $error("error raised without cause");
  property p_ehold; core_error_interrupt && !ctl_wr |=> core_error_interrupt; endproperty
  a_ehold: assert property (p_ehold) else $error("error interrupt dropped");
  property p_eclr; s_ack |=> !core_error_interrupt; endproperty
  a_eclr: assert property (p_eclr) else $error("acknowledge did not clear");
  property p_perm; sleep_exit_interrupt |=> !power_down_permit; endproperty
  a_perm: assert property (p_perm) else $error("permit kept after exit");
endmodule // rdc_sva

bind rdc_regs rdc_sva rdc_sva_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_exit_interrupt(sleep_exit_interrupt), .xmem_access_fault(xmem_access_fault),
  .master_clock_mhz(master_clock_mhz), .power_down_permit(power_down_permit),
  .port0_pins(port0_pins), .port1_pins(port1_pins),
  .core_error_interrupt(core_error_interrupt)
);

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the radio diagnostic and control register bank.
`timescale 1ns/10ps
`default_nettype none

module testbench
  import rdc_pkg::*;
;
  // ==========================================================================
  // Design signals and bench state.
  logic        ref_clk, reset_n, reg_wr, reg_rd, slow_clock_pin, slow_timer_reset;
  logic        core_clock_source, deep_sleep_request, sleep_exit_interrupt;
  logic        xmem_access_fault, slow_wake_event, sleep_state_flag;
  logic        power_down_permit, core_error_interrupt, probe_interrupt, rd_seen;
  logic        pol, en, seen;
  logic [31:0] reg_addr, reg_wdata, reg_rdata, cv, mv;
  logic [7:0]  wd [5];
  logic [7:0]  port0_pins, cfg;
  logic [3:0]  port1_pins;
  logic [5:0]  master_clock_mhz;
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int          error_cnt, num_checks, k, c, p, w, b;

  rdc_regs rdc_regs_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slow_clock_pin(slow_clock_pin), .slow_timer_reset(slow_timer_reset),
    .core_clock_source(core_clock_source), .deep_sleep_request(deep_sleep_request),
    .sleep_exit_interrupt(sleep_exit_interrupt), .xmem_access_fault(xmem_access_fault),
    .slow_wake_event(slow_wake_event), .sleep_state_flag(sleep_state_flag),
    .core_probe_word0(wd[0]), .core_probe_word1(wd[1]), .core_probe_word2(wd[2]),
    .rf_probe_word0(wd[3]), .rf_probe_word1(wd[4]), .master_clock_mhz(master_clock_mhz),
    .power_down_permit(power_down_permit), .port0_pins(port0_pins),
    .port1_pins(port1_pins), .core_error_interrupt(core_error_interrupt),
    .probe_interrupt(probe_interrupt)
  );

  // ==========================================================================
  // Clock at 4 ns period.
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(string name, logic [31:0] seen_v, logic [31:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(logic [31:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Reads note the expected word and the bits that matter for the monitor.
  task automatic rd(logic [31:0] a, logic [31:0] e, logic [31:0] m);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask

  // Slow clock only moves when a test asks, so monitor bits stay predictable.
  task automatic slow(int n);
    repeat (n)
    begin
      slow_clock_pin <= 1'b1;
      cyc(4);
      slow_clock_pin <= 1'b0;
      cyc(4);
    end
  endtask

  function automatic logic [7:0] pbus(logic [1:0] s, logic r);
    logic [7:0] v;
    case (s)
      2'd0:    v = {wd[2][7:5], wd[1][4:3], wd[0][2:0]};
      2'd1:    v = {wd[2][7:5], wd[1][4:3], wd[0][2], slow_wake_event, sleep_state_flag};
      2'd2:    v = wd[3];
      default: v = wd[4];
    endcase
    if (r)
      pbus = {<<{v}};
    else
      pbus = v;
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Read data appear one cycle after the strobe and are matched to the oldest note.
  initial
  begin
    rd_seen = 1'b0;
    forever
    begin
      @(posedge ref_clk);
      if (rd_seen)
        check("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
      rd_seen = reg_rd;
    end
  end

  // Watchdog sized well beyond the roughly 900 cycles the tests need.
  initial
  begin
    cyc(20000);
    error_cnt++;
    close_out();
  end

  // ==========================================================================
  // Main sequence.
  initial
  begin
    {reset_n, reg_wr, reg_rd, slow_clock_pin, slow_timer_reset, core_clock_source} = '0;
    {deep_sleep_request, sleep_exit_interrupt, xmem_access_fault} = '0;
    {slow_wake_event, sleep_state_flag, reg_addr, reg_wdata} = '0;
    void'($urandom(82041));
    for (k = 0; k < 5; k++)
      wd[k] = $urandom;
    cyc(20);
    reset_n <= 1'b1;
    rd(RDC_CTL_ADDR, 32'h0000_0004, '1);
    rd(RDC_DIAG_ADDR, 32'h0000_0000, '1);
    core_clock_source <= 1'b1;
    wr(RDC_CTL_ADDR, 32'h0000_21FF);
    wr(32'h4000_0208, 32'h0000_0000);
    rd(32'h4000_0208, 32'h0000_0000, '1);
    rd(RDC_CTL_ADDR, 32'h0000_207C, '1);
    check("master_clock_mhz", master_clock_mhz, 6'h10);
    // Every select and order with fresh random probe words.
    for (k = 0; k < 8; k++)
    begin
      for (c = 0; c < 5; c++)
        wd[c] <= $urandom;
      slow_wake_event  <= $urandom;
      sleep_state_flag <= $urandom;
      wr(RDC_CTL_ADDR, 32'h0000_2004 | (k << 3));
      cyc(4);
      check("port0_pins", port0_pins, pbus(k[1:0], k[2]));
      check("port1_pins", port1_pins, pbus(k[1:0], k[2]) & 8'h0F);
    end
    // Error flag, mask and acknowledge.
    xmem_access_fault <= 1'b1;
    cyc(1);
    xmem_access_fault <= 1'b0;
    cyc(1);
    check("core_error_interrupt", core_error_interrupt, 1'b1);
    wr(RDC_CTL_ADDR, 32'h0000_2000);
    cyc(1);
    check("core_error_interrupt", core_error_interrupt, 1'b0);
    rd(RDC_CTL_ADDR, 32'h0000_2041, 32'hFFFF_FE7F);
    wr(RDC_CTL_ADDR, 32'h0000_2004);
    cyc(1);
    check("core_error_interrupt", core_error_interrupt, 1'b1);
    wr(RDC_CTL_ADDR, 32'h0000_2007);
    cyc(1);
    check("core_error_interrupt", core_error_interrupt, 1'b0);
    rd(RDC_CTL_ADDR, 32'h0000_2044, 32'hFFFF_FE7F);
    // Slow clock monitor, blocked while the slow timer is in reset.
    slow_timer_reset <= 1'b1;
    slow(2);
    cyc(4);
    rd(RDC_CTL_ADDR, 32'h0000_0000, 32'h0000_0080);
    slow_timer_reset <= 1'b0;
    slow(2);
    cyc(4);
    rd(RDC_CTL_ADDR, 32'h0000_0080, 32'h0000_0080);
    wr(RDC_CTL_ADDR, 32'h0000_2004);
    rd(RDC_CTL_ADDR, 32'h0000_0000, 32'h0000_0080);
    // Power-down permit after slow edges, cleared on sleep exit.
    deep_sleep_request <= 1'b1;
    slow(3);
    cyc(4);
    check("power_down_permit", power_down_permit, 1'b1);
    rd(RDC_CTL_ADDR, 32'h0000_0100, 32'h0000_0100);
    sleep_exit_interrupt <= 1'b1;
    cyc(1);
    sleep_exit_interrupt <= 1'b0;
    cyc(1);
    check("power_down_permit", power_down_permit, 1'b0);
    deep_sleep_request <= 1'b0;
    // Each channel, word pick and edge; some with the channel disabled.
    for (k = 0; k < 32; k++)
    begin
      c   = k % 4;
      p   = (k / 4) % 4;
      pol = k[4];
      en  = (k % 7) != 3;
      b   = $urandom % 8;
      w   = (p < 2) ? p : p + 1;
      cfg = {1'b0, pol, b[2:0], p[1:0], en};
      cv  = {24'h0, cfg} << (8 * c);
      mv  = 32'h0000_00FF << (8 * c);
      wr(RDC_DIAG_ADDR, cv);
      wd[w][b] <= !pol;
      cyc(3);
      // This read drops any flag raised by the change of pick; config bits read back.
      rd(RDC_DIAG_ADDR, cv, mv & ~(32'h0000_0080 << (8 * c)));
      // The opposite edge must leave the flag clear.
      wd[w][b] <= pol;
      cyc(3);
      rd(RDC_DIAG_ADDR, cv, mv);
      wd[w][b] <= !pol;
      seen = 1'b0;
      repeat (6)
      begin
        @(posedge ref_clk);
        seen = seen | probe_interrupt;
      end
      check("probe_interrupt", seen, en);
      rd(RDC_DIAG_ADDR, cv | (32'h0000_0080 << (8 * c)), mv);
      rd(RDC_DIAG_ADDR, cv, mv);
    end
    cyc(3);
    close_out();
  end
endmodule // testbench

`default_nettype wire
